// ### common/acfc_pkg.sv
// Shared constants, types and timing for the strobe FIFO controller.
// Assumes a single 20 MHz system clock; device times are slowest grade.
package acfc_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int SYNC_STAGES   = 2;

  // Device timing, in ns
  localparam int T_PW_NS   = 25;
  localparam int T_WR_NS   = 10;
  localparam int T_PR_NS   = 25;
  localparam int T_ACC_NS  = 25;
  localparam int T_RR_NS   = 10;
  localparam int T_PMR_NS  = 25;
  localparam int T_RMR_NS  = 10;
  localparam int T_RPW_NS  = 25;
  localparam int T_PRT_NS  = 25;
  localparam int T_RTR_NS  = 10;
  localparam int T_FLAG_NS = 35;

  // Least time in whole cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  localparam logic [3:0] WR_LOW_CYC = 4'(cyc_min(T_PW_NS));
  localparam logic [3:0] WR_REC_CYC = 4'(cyc_min(T_WR_NS));
  localparam logic [3:0] RD_LOW_CYC = 4'(cyc_min(T_ACC_NS > T_PR_NS ? T_ACC_NS : T_PR_NS)
                                         + SYNC_STAGES);
  localparam logic [3:0] RD_REC_CYC = 4'(cyc_min(T_RR_NS));
  localparam logic [3:0] CLR_PRE_CYC = 4'(cyc_min(T_RPW_NS));
  localparam logic [3:0] CLR_LOW_CYC = 4'(cyc_min(T_PMR_NS));
  localparam logic [3:0] CLR_REC_CYC = 4'(cyc_min(T_RMR_NS));
  localparam logic [3:0] RT_LOW_CYC  = 4'(cyc_min(T_PRT_NS));
  localparam logic [3:0] RT_REC_CYC  = 4'(cyc_min(T_RTR_NS));
  // Flag delay plus synchroniser plus one cycle of margin
  localparam logic [3:0] SETTLE_CYC  = 4'(cyc_min(T_FLAG_NS) + SYNC_STAGES + 1);

  localparam int DEV_DEPTH   = 8192;
  localparam int WORD_W      = 9;
  localparam int BUF_DEPTH   = 16;

  typedef struct packed {
    logic store_n;
    logic fetch_n;
    logic replay_n;
    logic clear_all_n;
  } acfc_pins_t;

  localparam acfc_pins_t PINS_IDLE = '{store_n: 1'b1, fetch_n: 1'b1,
                                       replay_n: 1'b1, clear_all_n: 1'b1};

  typedef struct packed {
    logic full_n;
    logic empty_n;
    logic half_n;
  } acfc_flags_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CLR_PRE = 4'h1,
    ST_CLR_LOW = 4'h2,
    ST_CLR_REC = 4'h3,
    ST_WR_LOW  = 4'h4,
    ST_WR_REC  = 4'h5,
    ST_RD_LOW  = 4'h6,
    ST_RD_REC  = 4'h7,
    ST_RT_LOW  = 4'h8,
    ST_RT_REC  = 4'h9,
    ST_SETTLE  = 4'ha
  } acfc_state_t;

endpackage : acfc_pkg

// ### verilog/acfc_sync.sv
// Two-stage synchroniser for a bus of independent level signals.
// Assumes each bit is stable long enough to be caught; no bus coherency.
`timescale 1ns/10ps
`default_nettype none
module acfc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '1;
      q      <= '1;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : acfc_sync
`default_nettype wire

// ### verilog/acfc_fifo.sv
// Small synchronous buffer with valid/ready on both sides.
// Assumes one clock; read data comes out of a register.
`timescale 1ns/10ps
`default_nettype none
module acfc_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output var  logic         in_ready,
  // Drain side
  output var  logic         out_valid,
  output var  logic [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          rdy_q, rdy_d, vld_q, vld_d;
  logic [W-1:0]  dat_q, dat_d;
  logic          push, load;

  always_comb
  begin
    push   = in_valid && rdy_q;
    load   = (cnt_q != '0) && (!vld_q || out_ready);
    wptr_d = push ? AW'(wptr_q + 1'b1) : wptr_q;
    rptr_d = load ? AW'(rptr_q + 1'b1) : rptr_q;
    cnt_d  = cnt_q;
    if (push && !load)
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    else if (load && !push)
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    // Ready is registered so the source sees an honest full
    rdy_d = (cnt_d != (AW+1)'(DEPTH));
    dat_d = load ? mem_q[rptr_q] : dat_q;
    vld_d = load ? 1'b1 : (out_ready ? 1'b0 : vld_q);
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_q[wptr_q] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
      rdy_q  <= 1'b1;
      vld_q  <= 1'b0;
      dat_q  <= '0;
    end
    else
    begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q  <= cnt_d;
      rdy_q  <= rdy_d;
      vld_q  <= vld_d;
      dat_q  <= dat_d;
    end
  end

  assign in_ready  = rdy_q;
  assign out_valid = vld_q;
  assign out_data  = dat_q;
endmodule : acfc_fifo
`default_nettype wire

// ### verilog/acfc_ctrl.sv
// Controller that drives an asynchronous strobe FIFO part through its pins.
// Assumes the part's flags and data arrive unsynchronised; one 20 MHz clock.
// Function
// - Hold the input word stable across the store strobe's rising edge.
// - Keep both strobes high during replay and its recovery time.
// - Replay only when writes since clear do not exceed the part depth.
// - Standalone mode: chain input low, lead input high before clear.
// - Width expansion shares all controls; any part's flags may be watched.
// - Depth mode needs the chain ring and exactly one lead part.
// - Depth mode: composite flags by ORing; no half full or replay.
`timescale 1ns/10ps
`default_nettype none
module acfc_ctrl
  import acfc_pkg::*;
#(
  parameter int DEPTH  = acfc_pkg::DEV_DEPTH,
  parameter int NPARTS = 1
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // User write stream
  input  wire logic                      wr_valid,
  input  wire logic [acfc_pkg::WORD_W-1:0] wr_word,
  output var  logic                      wr_ready,
  // User read
  input  wire logic                      rd_req,
  output var  logic                      rd_valid,
  output var  logic [acfc_pkg::WORD_W-1:0] rd_word,
  // User control
  input  wire logic                      clear_req,
  input  wire logic                      replay_req,
  input  wire logic                      depth_mode,
  input  wire logic                      lead_first,
  // User status
  output var  logic                      st_full,
  output var  logic                      st_empty,
  output var  logic                      st_half,
  output var  logic                      busy,
  output var  logic                      replay_refused,
  // Part strobes and data
  output var  acfc_pkg::acfc_pins_t      pins,
  output var  logic [acfc_pkg::WORD_W-1:0] input_word,
  input  wire logic [acfc_pkg::WORD_W-1:0] output_word,
  // Part flags
  input  wire logic [NPARTS-1:0]         full_flag_n,
  input  wire logic [NPARTS-1:0]         empty_flag_n,
  input  wire logic                      half_full_flag_n,
  // Mode straps
  output var  logic                      lead_device_n,
  output var  logic                      chain_in_n_o,
  output var  logic                      chain_in_n_oe
);
  localparam int WCW = $clog2(DEPTH) + 2;
  localparam int SW  = 2*NPARTS + 1 + WORD_W;

  acfc_state_t          st_q, st_d;
  acfc_pins_t           pins_q, pins_d;
  logic [3:0]           tmr_q, tmr_d;
  logic [WORD_W-1:0]    inw_q, inw_d, rdw_q, rdw_d;
  logic [WCW-1:0]       wcnt_q, wcnt_d;
  logic                 rdv_q, rdv_d, rref_q, rref_d;
  logic                 rdp_q, rdp_d, rtp_q, rtp_d, clp_q, clp_d;
  logic                 mode_q, mode_d, lead_q, lead_d;
  logic                 full_q, full_d, empty_q, empty_d, half_q, half_d;
  logic                 busy_q, busy_d;
  logic [SW-1:0]        sync_q;
  logic [WORD_W-1:0]    out_s;
  acfc_flags_t          flg;
  logic                 buf_valid, buf_pop;
  logic [WORD_W-1:0]    buf_data;
  logic                 full_ok, empty_ok, rt_ok;

  acfc_fifo #(
    .W     (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (wr_valid),
    .in_data   (wr_word),
    .in_ready  (wr_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (buf_pop)
  );

  // Flags and read data come from the part's own timing domain
  acfc_sync #(
    .W (SW)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .d       ({full_flag_n, empty_flag_n, half_full_flag_n, output_word}),
    .q       (sync_q)
  );

  // Composite flags are the OR of the parts' active-low flags
  always_comb
  begin
    out_s       = sync_q[WORD_W-1:0];
    flg.half_n  = sync_q[WORD_W];
    flg.empty_n = |sync_q[WORD_W+NPARTS:WORD_W+1];
    flg.full_n  = |sync_q[SW-1:WORD_W+NPARTS+1];
  end

  always_comb
  begin
    full_ok  = flg.full_n;
    empty_ok = flg.empty_n;
    // Replay only while the part still holds every word written
    rt_ok    = !mode_q && (wcnt_q <= WCW'(DEPTH));
    st_d     = st_q;
    pins_d   = pins_q;
    tmr_d    = (tmr_q != 4'h0) ? 4'(tmr_q - 4'h1) : 4'h0;
    inw_d    = inw_q;
    rdw_d    = rdw_q;
    wcnt_d   = wcnt_q;
    rdv_d    = 1'b0;
    rref_d   = 1'b0;
    mode_d   = mode_q;
    lead_d   = lead_q;
    buf_pop  = 1'b0;
    rdp_d    = rdp_q;
    rtp_d    = rtp_q;
    clp_d    = clp_q;
    full_d   = !flg.full_n;
    empty_d  = !flg.empty_n;
    half_d   = !mode_q && !flg.half_n;
    case (st_q)
      ST_IDLE:
      begin
        if (clp_q)
        begin
          clp_d  = 1'b0;
          mode_d = depth_mode;
          lead_d = depth_mode ? !lead_first : 1'b1;
          st_d   = ST_CLR_PRE;
          tmr_d  = 4'(CLR_PRE_CYC - 4'h1);
        end
        else if (rtp_q)
        begin
          rtp_d = 1'b0;
          if (rt_ok)
          begin
            pins_d.replay_n = 1'b0;
            st_d  = ST_RT_LOW;
            tmr_d = 4'(RT_LOW_CYC - 4'h1);
          end
          else
            rref_d = 1'b1;
        end
        else if (rdp_q && empty_ok)
        begin
          pins_d.fetch_n = 1'b0;
          st_d  = ST_RD_LOW;
          tmr_d = 4'(RD_LOW_CYC - 4'h1);
        end
        else if (buf_valid && full_ok)
        begin
          buf_pop = 1'b1;
          inw_d   = buf_data;
          pins_d.store_n = 1'b0;
          st_d  = ST_WR_LOW;
          tmr_d = 4'(WR_LOW_CYC - 4'h1);
          if (wcnt_q <= WCW'(DEPTH))
            wcnt_d = WCW'(wcnt_q + 1'b1);
        end
      end
      ST_CLR_PRE:
        if (tmr_q == 4'h0)
        begin
          pins_d.clear_all_n = 1'b0;
          st_d  = ST_CLR_LOW;
          tmr_d = 4'(CLR_LOW_CYC - 4'h1);
        end
      ST_CLR_LOW:
        if (tmr_q == 4'h0)
        begin
          pins_d.clear_all_n = 1'b1;
          wcnt_d = '0;
          st_d   = ST_CLR_REC;
          tmr_d  = 4'(CLR_REC_CYC - 4'h1);
        end
      ST_CLR_REC, ST_WR_REC, ST_RD_REC, ST_RT_REC:
        if (tmr_q == 4'h0)
        begin
          // Flags lag every strobe; wait before trusting them
          st_d  = ST_SETTLE;
          tmr_d = 4'(SETTLE_CYC - 4'h1);
        end
      ST_WR_LOW:
        if (tmr_q == 4'h0)
        begin
          pins_d.store_n = 1'b1;
          st_d  = ST_WR_REC;
          tmr_d = 4'(WR_REC_CYC - 4'h1);
        end
      ST_RD_LOW:
        if (tmr_q == 4'h0)
        begin
          rdw_d = out_s;
          rdv_d = 1'b1;
          rdp_d = 1'b0;
          pins_d.fetch_n = 1'b1;
          st_d  = ST_RD_REC;
          tmr_d = 4'(RD_REC_CYC - 4'h1);
        end
      ST_RT_LOW:
        if (tmr_q == 4'h0)
        begin
          pins_d.replay_n = 1'b1;
          st_d  = ST_RT_REC;
          tmr_d = 4'(RT_REC_CYC - 4'h1);
        end
      ST_SETTLE:
        if (tmr_q == 4'h0)
          st_d = ST_IDLE;
      default:
      begin
        st_d   = ST_IDLE;
        pins_d = PINS_IDLE;
      end
    endcase
    // New requests win over the clear of their pending bit
    if (rd_req)
      rdp_d = 1'b1;
    if (replay_req)
      rtp_d = 1'b1;
    if (clear_req)
      clp_d = 1'b1;
    busy_d = (st_d != ST_IDLE);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q    <= ST_IDLE;
      pins_q  <= PINS_IDLE;
      tmr_q   <= 4'h0;
      inw_q   <= '0;
      rdw_q   <= '0;
      wcnt_q  <= '0;
      rdv_q   <= 1'b0;
      rref_q  <= 1'b0;
      rdp_q   <= 1'b0;
      rtp_q   <= 1'b0;
      clp_q   <= 1'b1;
      mode_q  <= 1'b0;
      lead_q  <= 1'b1;
      full_q  <= 1'b0;
      empty_q <= 1'b1;
      half_q  <= 1'b0;
      busy_q  <= 1'b1;
    end
    else
    begin
      st_q    <= st_d;
      pins_q  <= pins_d;
      tmr_q   <= tmr_d;
      inw_q   <= inw_d;
      rdw_q   <= rdw_d;
      wcnt_q  <= wcnt_d;
      rdv_q   <= rdv_d;
      rref_q  <= rref_d;
      rdp_q   <= rdp_d;
      rtp_q   <= rtp_d;
      clp_q   <= clp_d;
      mode_q  <= mode_d;
      lead_q  <= lead_d;
      full_q  <= full_d;
      empty_q <= empty_d;
      half_q  <= half_d;
      busy_q  <= busy_d;
    end
  end

  assign pins           = pins_q;
  assign input_word     = inw_q;
  assign rd_valid       = rdv_q;
  assign rd_word        = rdw_q;
  assign replay_refused = rref_q;
  assign st_full        = full_q;
  assign st_empty       = empty_q;
  assign st_half        = half_q;
  assign busy           = busy_q;
  assign lead_device_n  = lead_q;
  // Chain input is driven low only in standalone; the ring feeds it otherwise
  assign chain_in_n_o   = 1'b0;
  assign chain_in_n_oe  = !mode_q;

  a_store_full_ok: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(pins_q.store_n) |-> $past(flg.full_n))
    else $error("store strobe issued while part full");

  a_word_held: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(pins_q.store_n) |=> $stable(inw_q) ##1 $stable(inw_q))
    else $error("input word moved around store edge");

  a_fetch_nonempty: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(pins_q.fetch_n) |-> $past(flg.empty_n))
    else $error("fetch strobe issued while part empty");

  a_fetch_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(pins_q.fetch_n) |-> (!pins_q.fetch_n)[*3] ##1 (pins_q.fetch_n && rdv_q))
    else $error("fetch low length or capture wrong");

  a_replay_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(pins_q.replay_n) |-> (pins_q.store_n && pins_q.fetch_n)[*2])
    else $error("strobe active in replay recovery");

  a_replay_allowed: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(pins_q.replay_n) |-> !mode_q && (wcnt_q <= WCW'(DEPTH)))
    else $error("replay issued when not allowed");

  a_settle_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(pins_q.store_n) |-> ##1 (st_q == ST_SETTLE)[*4] ##1 (st_q == ST_IDLE))
    else $error("flags trusted too early after store");

  a_clear_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !pins_q.clear_all_n |-> pins_q.store_n && pins_q.fetch_n
      && $past(pins_q.store_n) && $past(pins_q.fetch_n))
    else $error("strobe active around clear");

  a_depth_no_half: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode_q |=> !half_q)
    else $error("half full reported in depth mode");

  a_standalone_strap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !mode_q |-> chain_in_n_oe && lead_q)
    else $error("standalone straps wrong");
endmodule : acfc_ctrl
`default_nettype wire

// ### verif/acfc_part_model.sv
// Behavioural strobe FIFO part that sits on the far side of the controller.
// Assumes one part; flags move on strobe edges; released data lines toggle.
`timescale 1ns/10ps
`default_nettype none
module acfc_part_model #(
  parameter int DEPTH = 8
) (
  // Strobes, data and strap from the controller
  input  wire acfc_pkg::acfc_pins_t pins,
  input  wire logic [8:0]           input_word,
  input  wire logic                 chain_in_n,
  // Data and flags back to the controller
  output var  logic [8:0]           output_word,
  output var  logic                 full_flag_n,
  output var  logic                 empty_flag_n,
  output var  logic                 half_full_flag_n,
  // Strobe seen where the part forbids one
  output var  logic                 misuse
);
  import acfc_pkg::*;
  logic [8:0] mem [DEPTH];
  int         wp, rp, cnt, nwr;
  logic       wgo, rgo, dmode;

  initial
  begin
    {misuse, dmode, wgo, rgo, empty_flag_n} = '0;
    {full_flag_n, half_full_flag_n} = 2'b11;
    output_word = 9'h000;
  end

  always @(negedge pins.clear_all_n)
  begin
    wp = 0;
    rp = 0;
    cnt = 0;
    nwr = 0;
    {wgo, rgo, empty_flag_n, full_flag_n, half_full_flag_n} = 5'b00011;
  end
  // Mode strap is read as the clear ends
  always @(posedge pins.clear_all_n) dmode = chain_in_n;

  always @(negedge pins.store_n)
  begin
    if (!pins.clear_all_n || !pins.replay_n || cnt == DEPTH) misuse = 1'b1;
    wgo = (cnt < DEPTH);
    if (wgo) full_flag_n = (cnt + 1 != DEPTH);
    if (wgo) half_full_flag_n = dmode || (cnt + 1 <= DEPTH / 2);
  end
  always @(posedge pins.store_n)
    if (wgo)
    begin
      mem[wp] = input_word;
      // Depth mode reuses the half pin as the token output
      if (dmode && wp == DEPTH - 1)
      begin
        half_full_flag_n = 1'b0;
        half_full_flag_n <= #60 1'b1;
      end
      wp = (wp + 1) % DEPTH;
      cnt++;
      nwr++;
      wgo = 1'b0;
      empty_flag_n = 1'b1;
    end

  always @(negedge pins.fetch_n)
  begin
    if (!pins.clear_all_n || !pins.replay_n || cnt == 0) misuse = 1'b1;
    rgo = (cnt > 0);
    if (rgo) empty_flag_n = (cnt != 1);
    if (rgo) output_word <= #10 mem[rp];
  end
  always @(posedge pins.fetch_n)
  begin
    // Floating outputs must not look like the last word
    output_word <= #15 ~output_word;
    if (rgo)
    begin
      rp = (rp + 1) % DEPTH;
      cnt--;
      full_flag_n = 1'b1;
      half_full_flag_n = dmode || (cnt <= DEPTH / 2);
      if (dmode && rp == 0)
      begin
        half_full_flag_n = 1'b0;
        half_full_flag_n <= #60 1'b1;
      end
      rgo = 1'b0;
    end
  end

  always @(negedge pins.replay_n)
    if (!dmode)
    begin
      rp = 0;
      cnt = (nwr > DEPTH) ? DEPTH : nwr;
      {full_flag_n, empty_flag_n} = {cnt != DEPTH, cnt != 0};
      half_full_flag_n = (cnt <= DEPTH / 2);
    end
endmodule : acfc_part_model
`default_nettype wire

// ### verif/test_async_cascadable_fifo_control.sv
// Self-checking bench for the strobe FIFO controller and its part model.
// Assumes a single 20 MHz clock; part depth shortened to 8 on both sides.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_async_cascadable_fifo_control;
  import acfc_pkg::*;
  localparam int DEP = 8;
  logic       sys_clk, rst_b, wr_valid, wr_ready, rd_req, rd_valid, clear_req, replay_req;
  logic       depth_mode, lead_first, st_full, st_empty, st_half, busy, replay_refused;
  logic       lead_device_n, chain_in_n_o, chain_in_n_oe, chain_in_n, misuse, seen;
  logic       full_flag_n, empty_flag_n, half_full_flag_n;
  logic [8:0] wr_word, rd_word, input_word, output_word;
  acfc_pins_t pins;
  int         fails, cmp_count, cyc;

  // Strap line has a pull-up when the controller lets go
  assign chain_in_n = chain_in_n_oe ? chain_in_n_o : 1'b1;

  acfc_ctrl #(.DEPTH(DEP), .NPARTS(1)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .wr_valid(wr_valid), .wr_word(wr_word),
    .wr_ready(wr_ready), .rd_req(rd_req), .rd_valid(rd_valid), .rd_word(rd_word),
    .clear_req(clear_req), .replay_req(replay_req), .depth_mode(depth_mode),
    .lead_first(lead_first), .st_full(st_full), .st_empty(st_empty), .st_half(st_half),
    .busy(busy), .replay_refused(replay_refused), .pins(pins), .input_word(input_word),
    .output_word(output_word), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
    .half_full_flag_n(half_full_flag_n), .lead_device_n(lead_device_n),
    .chain_in_n_o(chain_in_n_o), .chain_in_n_oe(chain_in_n_oe));

  acfc_part_model #(.DEPTH(DEP)) part_u (
    .pins(pins), .input_word(input_word), .chain_in_n(chain_in_n),
    .output_word(output_word), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
    .half_full_flag_n(half_full_flag_n), .misuse(misuse));

  function automatic logic [8:0] pat(input int i);
    return 9'(i * 37 + 5);
  endfunction : pat

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Quiet means busy low for six edges, since buffered stores leave short gaps
  task automatic idle;
    int q;
    q = 0;
    for (int i = 0; i < 3000 && q < 6; i++)
    begin
      @(posedge sys_clk);
      q = (busy === 1'b1) ? 0 : q + 1;
    end
    `CHK(q, 6)
  endtask : idle

  task automatic wait_rd(input logic [8:0] e);
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    `CHK({rd_valid, rd_word}, {1'b1, e})
  endtask : wait_rd

  task automatic rd(input logic [8:0] e);
    rd_req <= 1'b1;
    @(posedge sys_clk);
    rd_req <= 1'b0;
    wait_rd(e);
  endtask : rd

  // Leaves wr_valid high so that writes can run back to back
  task automatic wr(input logic [8:0] w);
    wr_valid <= 1'b1;
    wr_word  <= w;
    do @(posedge sys_clk); while (wr_ready !== 1'b1);
  endtask : wr

  task automatic pulse_clear;
    clear_req <= 1'b1;
    @(posedge sys_clk);
    clear_req <= 1'b0;
    idle();
  endtask : pulse_clear

  task automatic replay;
    replay_req <= 1'b1;
    @(posedge sys_clk);
    replay_req <= 1'b0;
    seen = 1'b0;
    repeat (20)
    begin
      @(posedge sys_clk);
      if (replay_refused === 1'b1) seen = 1'b1;
    end
  endtask : replay

  task automatic t_reset;
    idle();
    `CHK({st_empty, st_full, st_half}, 3'b100)
    `CHK(pins, PINS_IDLE)
    `CHK({chain_in_n_oe, lead_device_n}, 2'b11)
  endtask : t_reset

  task automatic t_fill_drain;
    int k, q;
    k = 0;
    q = 0;
    while (q < 12 && k < 60)
    begin
      wr_valid <= 1'b1;
      wr_word  <= pat(k);
      @(posedge sys_clk);
      if (wr_ready === 1'b1) k++;
      q = (wr_ready === 1'b1) ? 0 : q + 1;
    end
    wr_valid <= 1'b0;
    `CHK(k >= DEP + 16, 1'b1)
    idle();
    `CHK({st_full, st_half, misuse}, 3'b110)
    // Only the part's own depth was stored so far, so replay is still allowed
    replay();
    `CHK(seen, 1'b0)
    for (int i = 0; i < k; i++) rd(pat(i));
    idle();
    `CHK({st_empty, st_full, st_half}, 3'b100)
    replay();
    `CHK(seen, 1'b1)
  endtask : t_fill_drain

  task automatic t_replay;
    pulse_clear();
    for (int i = 0; i < 5; i++) wr(pat(100 + i));
    wr_valid <= 1'b0;
    idle();
    `CHK(st_half, 1'b1)
    rd(pat(100));
    idle();
    `CHK(st_half, 1'b0)
    for (int i = 1; i < 5; i++) rd(pat(100 + i));
    idle();
    `CHK(st_empty, 1'b1)
    replay();
    idle();
    `CHK({seen, st_empty, st_half}, 3'b001)
    wr(pat(200));
    wr_valid <= 1'b0;
    for (int i = 0; i < 5; i++) rd(pat(100 + i));
    rd(pat(200));
    rd_req <= 1'b1;
    @(posedge sys_clk);
    rd_req <= 1'b0;
    repeat (40) @(posedge sys_clk);
    `CHK(misuse, 1'b0)
    wr(pat(300));
    wr_valid <= 1'b0;
    wait_rd(pat(300));
  endtask : t_replay

  task automatic t_depth;
    depth_mode <= 1'b1;
    lead_first <= 1'b1;
    pulse_clear();
    `CHK({chain_in_n_oe, lead_device_n}, 2'b00)
    replay();
    `CHK(seen, 1'b1)
    for (int i = 0; i < DEP; i++) wr(pat(400 + i));
    wr_valid <= 1'b0;
    idle();
    `CHK({st_half, st_empty}, 2'b00)
    for (int i = 0; i < DEP; i++) rd(pat(400 + i));
  endtask : t_depth

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Whole run needs about a thousand cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  initial
  begin
    {rst_b, wr_valid, rd_req, clear_req, replay_req, depth_mode, lead_first} = '0;
    wr_word = 9'h000;
    fails = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_fill_drain();
    t_replay();
    t_depth();
    end_sim();
  end
endmodule : test_async_cascadable_fifo_control
`default_nettype wire
